//--- inc/mqr_pkg.sv
// Constants and types shared by the multi-queue read port.
// Assumes a single 250 MHz read clock and a Wishbone register bus.
package mqr_pkg;
  localparam int QW  = 36;
  localparam int NQ  = 32;
  localparam int QD  = 8;
  localparam int QAW = 5;
  localparam int PW  = 3;
  localparam int CW  = 4;

  localparam int MARK_START = 32;
  localparam int MARK_END   = 33;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_PUSH   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_LEVEL  = 8'h10;

  localparam int CTRL_ID_LSB   = 0;
  localparam int CTRL_QCNT_LSB = 8;
  localparam int PUSH_MARK_LSB = 0;
  localparam int PUSH_Q_LSB    = 8;

  localparam logic [31:0]   CTRL_RST = 32'h0000_1F00;
  localparam logic [CW-1:0] AE_LEVEL = 4'h2;
  localparam logic [5:0]    QCNT_16  = 6'h10;
  localparam logic [5:0]    QCNT_32  = 6'h20;
  localparam int            FIRST_WORD_EDGES = 2;

  typedef enum logic [1:0] {
    QS_WRADDR = 2'b00,
    QS_RDADDR = 2'b01,
    QS_FIX16  = 2'b10,
    QS_FIX32  = 2'b11
  } mqr_qcfg_t;

  typedef enum logic [1:0] {
    RS_IDLE   = 2'b00,
    RS_WAIT1  = 2'b01,
    RS_WAIT2  = 2'b10,
    RS_ACTIVE = 2'b11
  } mqr_rd_state_t;
endpackage

//--- inc/mqr_cfg_if.sv
// Configuration latched at master reset (a code 00 queue count tracks CTRL), shared by the read port parts.
// Assumes one producer (the strap latch) and any number of readers.
`timescale 1ns/100ps
interface mqr_cfg_if;
  logic       done;
  logic       packet_mode;
  logic       polled;
  logic [5:0] qcount;
  modport src (output done, output packet_mode, output polled,
               output qcount);
  modport dst (input done, input packet_mode, input polled,
               input qcount);
endinterface

//--- design/mqr_cfg_latch.sv
// Catches the mode straps at the first edge after master reset.
// Assumes the straps are steady around reset release.
`timescale 1ns/100ps
module mqr_cfg_latch
  import mqr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       packet_mode_select,
  input  wire logic       flag_poll_mode_select,
  input  wire logic [1:0] queue_config_select,
  input  wire logic [4:0] rd_addr_low,
  input  wire logic [4:0] wr_count_m1,
  mqr_cfg_if.src          cfg
);
  mqr_qcfg_t cfg_code;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg.done        <= 1'b0;
      cfg.packet_mode <= 1'b0;
      cfg.polled      <= 1'b0;
      cfg_code        <= QS_FIX32;
    end else if (!cfg.done) begin
      cfg.done        <= 1'b1;
      cfg.packet_mode <= packet_mode_select;
      cfg.polled      <= flag_poll_mode_select;
      cfg_code        <= mqr_qcfg_t'(queue_config_select);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg.qcount <= QCNT_32;
    end else begin
      case (cfg.done ? cfg_code : mqr_qcfg_t'(queue_config_select))
        QS_WRADDR: cfg.qcount <= {1'b0, wr_count_m1} + 6'h01;
        QS_RDADDR: if (!cfg.done) cfg.qcount <= {1'b0, rd_addr_low} + 6'h01;
        QS_FIX16:  cfg.qcount <= QCNT_16;
        default:   cfg.qcount <= QCNT_32;
      endcase
    end
  end

  chk_fixed_sixteen: assert property (
    @(posedge clk) disable iff (reset)
    cfg.done && cfg_code == QS_FIX16 |=> cfg.qcount == QCNT_16)
    else $error("fixed 16-queue count wrong");
endmodule // mqr_cfg_latch

//--- design/mqr_flag_scan.sv
// Drives the eight-bit read flag status bus, direct or polled.
// Assumes st_n holds one active-low status bit per queue.
`timescale 1ns/100ps
module mqr_flag_scan
  import mqr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  mqr_cfg_if.dst             cfg,
  input  wire logic [NQ-1:0] st_n,
  input  wire logic          strobe,
  input  wire logic [7:0]    addr,
  input  wire logic [2:0]    dev_id,
  input  wire logic          token_in,
  output logic      [7:0]    bus_n,
  output logic               frame_sync,
  output logic               token_out,
  output logic               token_seen
);
  logic [1:0] wsel;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wsel <= 2'h0;
    end else if (cfg.polled) begin
      wsel <= wsel + 2'h1;
    end else if (strobe && addr[7:5] == dev_id) begin
      wsel <= addr[1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_n      <= 8'hFF;
      frame_sync <= 1'b0;
    end else begin
      bus_n      <= cfg.done ? st_n[wsel*8 +: 8] : 8'hFF;
      frame_sync <= cfg.done && cfg.polled && wsel == 2'h0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      token_out  <= 1'b0;
      token_seen <= 1'b0;
    end else begin
      token_out  <= cfg.done && cfg.polled && wsel == 2'h3;
      token_seen <= token_in;
    end
  end

  chk_poll_sync: assert property (
    @(posedge clk) disable iff (reset)
    frame_sync |=> !frame_sync [*3])
    else $error("frame sync not once per four words");
endmodule // mqr_flag_scan

//--- design/mqr_read_port.sv
// Read port of a 32-queue packet-aware FIFO with Wishbone access.
// Assumes host read logic on clk; software fills queues over the bus.
//
// Notes on behaviour
// - packet ready shows selected read queue
// - packet mode strap caught at reset
// - packet ready needs packet mode and a selected queue
// - flag low while complete packet held
// - word given when read and output enabled
// - top four bits carry packet markers
// - codes 00/01 program queue count
// - codes 10/11 fix 16/32 queues
// - strobe edge selects addressed read queue
// - direct mode strobe picks status word
// - polled mode steps words, frame sync
// - read flags updated on read clock
// - expansion tokens timed by read clock
// - high strap packet, low almost-empty
// - flag bus shows packet or almost-empty
// - first word two edges after select
// - low five bits queue, top three device
`timescale 1ns/100ps
module mqr_read_port
  import mqr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          packet_mode_select,
  input  wire logic          flag_poll_mode_select,
  input  wire logic [1:0]    queue_config_select,
  input  wire logic          read_queue_address_strobe,
  input  wire logic [7:0]    read_queue_address,
  input  wire logic          read_flag_status_strobe,
  input  wire logic          read_enable_n,
  input  wire logic          output_enable_n,
  input  wire logic          expansion_token_in,
  output logic      [QW-1:0] read_data,
  output logic               empty_or_output_ready_n,
  output logic               packet_ready_flag_n,
  output logic               almost_empty_flag_n,
  output logic      [7:0]    read_flag_status_bus_n,
  output logic               read_flag_frame_sync,
  output logic               expansion_token_out
);
  mqr_cfg_if cfg ();

  logic [31:0]    ctrl;
  logic [31:0]    wdata_lo;
  logic [31:0]    rd_mux;
  logic           acc;
  logic           wr_en;
  logic           token_seen;
  logic [2:0]     dev_id;

  logic [QW-1:0]  mem [NQ*QD];
  logic [PW-1:0]  wp  [NQ];
  logic [PW-1:0]  rp  [NQ];
  logic [CW-1:0]  cnt [NQ];
  logic [CW-1:0]  packets [NQ];
  logic [NQ-1:0]  st_n;

  mqr_rd_state_t  rd_state;
  mqr_rd_state_t  next_rd_state;
  logic [QAW-1:0] cur_q;
  logic [CW-1:0]  cnt_cur;
  logic [CW-1:0]  packets_cur;
  logic [PW-1:0]  rp_cur;
  logic           sel_hit;
  logic           take;
  logic           take_end;
  logic           push_ok;
  logic           push_end;
  logic           same_q;
  logic [QAW-1:0] push_q;
  logic [QW-1:0]  push_word;
  logic           next_valid;
  logic [QW-1:0]  next_data;

  function automatic logic [31:0] mqr_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  mqr_cfg_latch u_cfg (
    .clk                   (clk),
    .reset                 (reset),
    .packet_mode_select    (packet_mode_select),
    .flag_poll_mode_select (flag_poll_mode_select),
    .queue_config_select   (queue_config_select),
    .rd_addr_low           (read_queue_address[4:0]),
    .wr_count_m1           (ctrl[CTRL_QCNT_LSB +: 5]),
    .cfg                   (cfg)
  );

  mqr_flag_scan u_flag (
    .clk        (clk),
    .reset      (reset),
    .cfg        (cfg),
    .st_n       (st_n),
    .strobe     (read_flag_status_strobe),
    .addr       (read_queue_address),
    .dev_id     (dev_id),
    .token_in   (expansion_token_in),
    .bus_n      (read_flag_status_bus_n),
    .frame_sync (read_flag_frame_sync),
    .token_out  (expansion_token_out),
    .token_seen (token_seen)
  );

  // Wishbone slave, one wait cycle, writes land on the ack edge
  assign acc    = wb_cyc_i && wb_stb_i;
  assign wr_en  = acc && wb_we_i && wb_ack_o;
  assign dev_id = ctrl[CTRL_ID_LSB +: 3];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc && !wb_ack_o;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl     <= CTRL_RST;
      wdata_lo <= 32'h0000_0000;
    end else if (wr_en && wb_adr_i == REG_CTRL) begin
      ctrl <= mqr_merge(ctrl, wb_dat_i, wb_sel_i);
    end else if (wr_en && wb_adr_i == REG_WDATA) begin
      wdata_lo <= mqr_merge(wdata_lo, wb_dat_i, wb_sel_i);
    end
  end

  always_comb begin
    case (wb_adr_i)
      REG_CTRL:   rd_mux = ctrl;
      REG_WDATA:  rd_mux = wdata_lo;
      REG_STATUS: rd_mux = {10'h000, cfg.qcount, 2'h0, token_seen,
                            cfg.done, cfg.polled, cfg.packet_mode,
                            rd_state, 3'h0, cur_q};
      REG_LEVEL:  rd_mux = {20'h00000, packets_cur, 4'h0, cnt_cur};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Queue fill from software stands in for the write port
  assign push_q    = wb_dat_i[PUSH_Q_LSB +: QAW];
  assign push_word = {wb_dat_i[PUSH_MARK_LSB +: 4], wdata_lo};
  assign push_ok   = wr_en && wb_adr_i == REG_PUSH
                     && cnt[push_q] != CW'(QD)
                     && {1'b0, push_q} < cfg.qcount;
  assign push_end  = push_ok && push_word[MARK_END];

  assign cnt_cur     = cnt[cur_q];
  assign packets_cur = packets[cur_q];
  assign rp_cur      = rp[cur_q];

  assign sel_hit = cfg.done && read_queue_address_strobe
                   && read_queue_address[7:5] == dev_id
                   && {1'b0, read_queue_address[4:0]} < cfg.qcount;

  assign take     = !empty_or_output_ready_n && !read_enable_n
                    && !output_enable_n;
  assign take_end = take && read_data[MARK_END];
  assign same_q   = push_q == cur_q;

  always_ff @(posedge clk) begin
    if (push_ok) mem[{push_q, wp[push_q]}] <= push_word;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NQ; i++) begin
        wp[i]  <= '0;
        rp[i]  <= '0;
        cnt[i] <= '0;
        packets[i] <= '0;
      end
    end else begin
      if (push_ok) begin
        wp[push_q] <= wp[push_q] + 3'h1;
        if (!(take && same_q)) cnt[push_q] <= cnt[push_q] + 4'h1;
      end
      // Only an end marker completes a packet
      if (push_end && !(take_end && same_q)) begin
        packets[push_q] <= packets[push_q] + 4'h1;
      end
      if (take) begin
        rp[cur_q] <= rp_cur + 3'h1;
        if (!(push_ok && same_q)) cnt[cur_q] <= cnt_cur - 4'h1;
        if (take_end && !(push_end && same_q)) begin
          packets[cur_q] <= packets_cur - 4'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      st_n[i] = cfg.packet_mode ? (packets[i] == 4'h0) : (cnt[i] > AE_LEVEL);
    end
  end

  always_comb begin
    case (rd_state)
      RS_IDLE:   next_rd_state = RS_IDLE;
      RS_WAIT1:  next_rd_state = RS_WAIT2;
      RS_WAIT2:  next_rd_state = RS_ACTIVE;
      RS_ACTIVE: next_rd_state = RS_ACTIVE;
      default:   next_rd_state = RS_IDLE;
    endcase
    if (sel_hit) next_rd_state = RS_WAIT1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_state <= RS_IDLE;
      cur_q    <= '0;
    end else begin
      rd_state <= next_rd_state;
      if (sel_hit) cur_q <= read_queue_address[4:0];
    end
  end

  // Output word holds the head; a read pops it and shows the next
  always_comb begin
    next_valid = !empty_or_output_ready_n;
    next_data  = read_data;
    if (sel_hit) begin
      next_valid = 1'b0;
    end else if (take) begin
      next_valid = cnt_cur >= 4'h2;
      if (cnt_cur >= 4'h2) next_data = mem[{cur_q, rp_cur + 3'h1}];
    end else if (empty_or_output_ready_n && cnt_cur != 4'h0
                 && (rd_state == RS_WAIT2 || rd_state == RS_ACTIVE)) begin
      next_valid = 1'b1;
      next_data  = mem[{cur_q, rp_cur}];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_data               <= '0;
      empty_or_output_ready_n <= 1'b1;
    end else begin
      read_data               <= next_data;
      empty_or_output_ready_n <= !next_valid;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      packet_ready_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b1;
    end else begin
      packet_ready_flag_n <= !(cfg.packet_mode && rd_state != RS_IDLE
                               && packets_cur != 4'h0);
      almost_empty_flag_n <= !(rd_state != RS_IDLE
                               && cnt_cur <= AE_LEVEL);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_no_early_word: assert property (
    sel_hit |=> empty_or_output_ready_n [*2])
    else $error("word shown before two edges");

  chk_first_word_due: assert property (
    rd_state == RS_WAIT2 && cnt_cur != 4'h0 && !sel_hit
    |=> !empty_or_output_ready_n)
    else $error("first word missing two edges after select");

  chk_idle_no_data: assert property (
    rd_state == RS_IDLE |-> empty_or_output_ready_n && read_data == '0)
    else $error("data valid before any select");

  chk_ready_inactive: assert property (
    cfg.done && !cfg.packet_mode |=> packet_ready_flag_n)
    else $error("packet ready active outside packet mode");

  chk_ready_held: assert property (
    cfg.packet_mode && rd_state != RS_IDLE && packets_cur != 4'h0
    && !sel_hit |=> !packet_ready_flag_n)
    else $error("packet ready high with packet held");

  chk_take_pops: assert property (
    take && !sel_hit && !(push_ok && same_q)
    |=> cnt_cur == $past(cnt_cur) - 4'h1)
    else $error("read did not pop the queue");

  chk_take_next: assert property (
    take && !sel_hit && cnt_cur >= 4'h2 |=> !empty_or_output_ready_n)
    else $error("back-to-back word lost");

  chk_select_queue: assert property (
    sel_hit |=> cur_q == $past(read_queue_address[4:0]))
    else $error("read queue not taken from address");

  chk_other_device: assert property (
    read_queue_address_strobe && read_queue_address[7:5] != dev_id
    |=> $stable(cur_q))
    else $error("queue changed for another device id");

  chk_ae_flag: assert property (
    rd_state != RS_IDLE && !sel_hit && cnt_cur <= AE_LEVEL
    |=> !almost_empty_flag_n)
    else $error("almost-empty flag missed");

  cov_select: cover property (sel_hit ##2 !empty_or_output_ready_n);
  cov_packet_end: cover property (take_end ##1 packet_ready_flag_n);
  cov_burst: cover property (take [*3]);
endmodule // mqr_read_port

//--- sim/mqr_host_reader.sv
// Host reader model: drives queue select, flag select and read enables.
// Assumes the bench raises requests by non-blocking updates on rising edges.
`timescale 1ns/100ps
module mqr_host_reader (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sel_req,
  input  wire logic       flag_req,
  input  wire logic [7:0] sel_addr,
  input  wire logic       take,
  output logic            strobe,
  output logic            flag_strobe,
  output logic      [7:0] addr,
  output logic            ren_n,
  output logic            oe_n
);
  logic [1:0] warm;
  logic [7:0] noise;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      warm  <= 2'h0;
      noise <= 8'h5A;
    end else begin
      if (warm != 2'h2)
        warm <= warm + 2'h1;
      noise <= noise + 8'h35;
    end
  end

  // strobes only on request, never together
  assign strobe      = sel_req & (warm == 2'h2);
  assign flag_strobe = flag_req & ~sel_req & (warm == 2'h2);
  // Address is meaningless between selects, so it keeps moving
  assign addr = (warm != 2'h2 | sel_req | flag_req) ? sel_addr : noise;
  assign ren_n = ~take;
  assign oe_n  = ~take;
endmodule // mqr_host_reader

//--- sim/tb_multi_queue_read_port.sv
// Testbench for the read port: Wishbone fills queues, a reader model
// selects and drains them, and a queue model predicts every word read, the four direct-mode flag bus words and word 0 at each polled frame sync.
// Assumes the reader model in mqr_host_reader.sv.
`timescale 1ns/100ps
module tb_multi_queue_read_port;
  import mqr_pkg::*;
  logic        clk, reset, cyc, stb, we, ack, pmode, poll, tok_in;
  logic        sel_req, flag_req, take, strobe, fstrobe, ren_n, oe_n;
  logic        eor_n, prdy_n, ae_n, fsync, tok_out;
  logic [1:0]  qcfg;
  logic [7:0]  adr, sel_addr, addr, fbus_n;
  logic [31:0] wdat, rdat, st;
  logic [35:0] rd_data;
  logic [35:0] mq [NQ][$];
  integer      seed, miscompares, comparisons;

  mqr_read_port dut (
    .clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .packet_mode_select(pmode),
    .flag_poll_mode_select(poll), .queue_config_select(qcfg),
    .read_queue_address_strobe(strobe), .read_queue_address(addr),
    .read_flag_status_strobe(fstrobe), .read_enable_n(ren_n),
    .output_enable_n(oe_n), .expansion_token_in(tok_in),
    .read_data(rd_data), .empty_or_output_ready_n(eor_n),
    .packet_ready_flag_n(prdy_n), .almost_empty_flag_n(ae_n),
    .read_flag_status_bus_n(fbus_n), .read_flag_frame_sync(fsync),
    .expansion_token_out(tok_out));
  mqr_host_reader host (
    .clk, .reset, .sel_req, .flag_req, .sel_addr, .take, .strobe,
    .flag_strobe(fstrobe), .addr, .ren_n, .oe_n);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [35:0] mkw(logic [1:0] m);
    mkw = {2'b00, m, 32'($random(seed))};
  endfunction

  function automatic logic [7:0] exp_word(int w, logic pm);
    int q;
    int ends;
    exp_word = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      q = 8 * w + i;
      ends = 0;
      for (int j = 0; j < mq[q].size(); j++)
        ends += mq[q][j][MARK_END];
      if (pm ? ends > 0 : mq[q].size() <= 2)
        exp_word[i] = 1'b0;
    end
  endfunction

  task automatic wrap_up;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timed_out;
    miscompares++;
    $display("Wait limit reached at %0t", $time);
    wrap_up();
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      timed_out();
    st = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // writer marks packets and fills one queue at a time
  task automatic push(input int q, input logic [35:0] d);
    wb(1'b1, REG_WDATA, d[31:0]);
    wb(1'b1, REG_PUSH, {19'h0, q[4:0], 4'h0, d[35:32]});
    mq[q].push_back(d);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic p, input logic f,
                          input logic [1:0] qs);
    @(posedge clk);
    reset <= 1'b1;
    pmode <= p;
    poll <= f;
    qcfg <= qs;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (mq[i]) mq[i].delete();
  endtask

  task automatic select_q(input logic [7:0] a);
    @(posedge clk);
    sel_req <= 1'b1;
    sel_addr <= a;
    @(posedge clk);
    sel_req <= 1'b0;
  endtask

  task automatic read_word(input int q);
    int n;
    n = 0;
    #1;
    while (eor_n !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20)
      timed_out();
    check(rd_data, mq[q][0]);
    mq[q].delete(0);
    @(posedge clk);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    timed_out();
  end

  initial begin
    int q;
    int q2;
    int syncs;
    int last;
    seed = 18890;
    miscompares = 0;
    comparisons = 0;
    {cyc, stb, we, take, sel_req, flag_req, poll} = '0;
    adr = 8'h00;
    wdat = 32'h0;
    sel_addr = 8'h06;
    tok_in = 1'b1;
    reset = 1'b1;
    pmode = 1'b1;
    qcfg = 2'b11;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[0], 1'b0, k[1:0]);
      tok_in <= k[1];
      check(rd_data, 36'h0);
      check(eor_n, 1'b1);
      wb(1'b0, REG_STATUS, 32'h0);
      check(st[21:16], k == 1 ? 6'h07 : k == 2 ? QCNT_16 : QCNT_32);
      check(st[10], k[0]);
      check(st[13:12], {k[1], 1'b1});
      if (k == 1) begin
        select_q(8'h03);
        select_q(8'h09);
        select_q(8'h25);
        wb(1'b0, REG_STATUS, 32'h0);
        check(st[4:0], 5'h03);
      end
      $display("Strap code %0d test done", k);
    end
    do_reset(1'b1, 1'b0, 2'b11);
    wb(1'b0, 8'h20, 32'h0);
    check(st, 32'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    check(st, CTRL_RST);
    q = $unsigned($random(seed)) % 24;
    q2 = q + 8;
    select_q(q[7:0]);
    push(q, mkw(2'b01));
    settle();
    check({prdy_n, eor_n}, 2'b10);
    push(q, mkw(2'b00));
    push(q, mkw(2'b10));
    settle();
    check({prdy_n, eor_n, ae_n}, 3'b001);
    wb(1'b0, REG_LEVEL, 32'h0);
    check(st[11:0], 12'h103);
    push(q2, mkw(2'b01));
    push(q2, mkw(2'b10));
    for (int i = 0; i < 3; i++) read_word(q);
    settle();
    check({prdy_n, eor_n, ae_n}, 3'b110);
    for (int w = 0; w < 4; w++) begin
      @(posedge clk);
      flag_req <= 1'b1;
      sel_addr <= w[7:0];
      @(posedge clk);
      flag_req <= 1'b0;
      settle();
      check(fbus_n, exp_word(w, 1'b1));
    end
    select_q(q2[7:0]);
    @(posedge clk);
    #1;
    check(eor_n, 1'b1);
    @(posedge clk);
    #1;
    check({eor_n, rd_data}, {1'b0, mq[q2][0]});
    settle();
    check(prdy_n, 1'b0);
    read_word(q2);
    read_word(q2);
    $display("Packet mode test done");
    do_reset(1'b0, 1'b1, 2'b10);
    for (int i = 0; i < 3; i++)
      push(1, mkw(i == 0 ? 2'b01 : i == 2 ? 2'b10 : 2'b00));
    select_q(8'h01);
    settle();
    check({prdy_n, ae_n}, 2'b11);
    syncs = 0;
    last = -1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      if (fsync === 1'b1) begin
        syncs++;
        last = i;
        check(fbus_n, exp_word(0, 1'b0));
      end
      if (tok_out === 1'b1 && last >= 0)
        check(i - last, 3);
    end
    check(syncs, 3);
    read_word(1);
    settle();
    check({prdy_n, ae_n}, 2'b10);
    $display("Almost-empty polled test done");
    wrap_up();
  end
endmodule // tb_multi_queue_read_port
